// *** design/hsz_home_search.sv ***
/*
  Per-axis automatic home search sequencer with an AXI4-Lite register
  slave, input synchronisers and the servo error clear pulse output.
  Assumes a pulse generator on aclk that follows drive_r and returns
  one drive_pulse per output step; pins are asynchronous.
*/
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`include "hsz_consts.svh"
`default_nettype none
module hsz_home_search #(
  parameter int unsigned CLR_UNIT_CYC = `HSZ_CLR_UNIT_CYC
) (
  input wire logic aclk,
  input wire logic aclken,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic home_sensor_input_n,
  input wire logic encoder_index_input_n,
  input wire logic limit_plus_in,
  input wire logic limit_minus_in,
  input wire logic drive_pulse,
  output logic servo_error_clear_output,
  output hsz_pkg::hsz_drive_s drive_r,
  output hsz_pkg::hsz_pos_clr_s pos_clr_r,
  output logic [31:0] speed_r,
  output logic [31:0] accel_r,
  output logic [31:0] init_speed_r
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic hsz_pkg::hsz_state_e from_step(
    input logic [2:0] n, input logic [15:0] m);
    from_step = hsz_pkg::HSZ_DONE;
    if (n <= 3'h4 && m[`HSZ_M1_S4_EX]) from_step = hsz_pkg::HSZ_S4;
    if (n <= 3'h3 && m[`HSZ_M1_S3_EX]) from_step = hsz_pkg::HSZ_S3;
    if (n <= 3'h2 && m[`HSZ_M1_S2_EX]) from_step = hsz_pkg::HSZ_S2;
    if (n <= 3'h1 && m[`HSZ_M1_S1_EX]) from_step = hsz_pkg::HSZ_S1;
  endfunction

  // clear pulse width in 10 us units; code 2 gives 100 us
  function automatic logic [11:0] clr_factor(input logic [2:0] c);
    case (c)
      3'h0: clr_factor = 12'h001;
      3'h1: clr_factor = 12'h002;
      3'h2: clr_factor = 12'h00A;
      3'h3: clr_factor = 12'h014;
      3'h4: clr_factor = 12'h064;
      3'h5: clr_factor = 12'h0C8;
      3'h6: clr_factor = 12'h3E8;
      default: clr_factor = 12'h7D0;
    endcase
  endfunction

  function automatic logic [15:0] merge16(
    input logic [15:0] old, input logic [15:0] nw, input logic [1:0] s);
    merge16 = {s[1] ? nw[15:8] : old[15:8], s[0] ? nw[7:0] : old[7:0]};
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_raw;
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic idx_d_r;
  assign pin_raw = {limit_minus_in, limit_plus_in,
                    encoder_index_input_n, home_sensor_input_n};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      always_ff @(posedge aclk)
      begin
        // reset to the idle pin level so no false edge follows reset
        if (!aresetn)
        begin
          sync1_r[gi] <= 1'b1;
          sync2_r[gi] <= 1'b1;
        end
        else if (aclken)
        begin
          sync1_r[gi] <= pin_raw[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      idx_d_r <= 1'b1;
    else if (aclken)
      idx_d_r <= sync2_r[1];
  end

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  logic wr_rdy_r;
  logic rd_rdy_r;
  logic wr_hs;
  logic rd_hs;
  logic wr_ok;
  logic cmd_go;
  logic [15:0] lo_r;
  logic [15:0] hi_r;
  logic [15:0] limcfg_r;
  logic [15:0] mode1_r;
  logic [15:0] mode2_r;
  logic [15:0] status;
  logic [15:0] rd_val;
  logic rd_ok;
  logic [31:0] par;
  logic [31:0] spd_hi_r;
  logic [31:0] spd_lo_r;
  logic [31:0] ofs_r;

  assign awready = wr_rdy_r;
  assign wready = wr_rdy_r;
  assign arready = rd_rdy_r;
  // both channels are taken on one edge once both are offered
  assign wr_hs = wr_rdy_r & awvalid & wvalid;
  assign rd_hs = rd_rdy_r & arvalid;
  assign wr_ok = awaddr == `HSZ_A_CMD || awaddr == `HSZ_A_LOW ||
                 awaddr == `HSZ_A_HIGH || awaddr == `HSZ_A_LIMCFG;
  // a command needs both low byte lanes to be meaningful
  assign cmd_go = wr_hs && awaddr == `HSZ_A_CMD && wstrb[1:0] == 2'h3;
  assign par = {hi_r, lo_r};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_rdy_r <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
    end
    else if (aclken)
    begin
      wr_rdy_r <= !wr_rdy_r && !bvalid && awvalid && wvalid;
      if (wr_hs)
      begin
        bvalid <= 1'b1;
        bresp <= wr_ok ? 2'h0 : 2'h2;
      end
      else if (bready)
        bvalid <= 1'b0;
    end
  end

  always_comb
  begin
    rd_ok = 1'b1;
    case (araddr)
      `HSZ_A_CMD: rd_val = `HSZ_RST16;
      `HSZ_A_LOW: rd_val = lo_r;
      `HSZ_A_HIGH: rd_val = hi_r;
      `HSZ_A_LIMCFG: rd_val = limcfg_r;
      `HSZ_A_MODE1: rd_val = mode1_r;
      `HSZ_A_MODE2: rd_val = mode2_r;
      `HSZ_A_STATUS: rd_val = status;
      default:
      begin
        rd_val = `HSZ_RST16;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_rdy_r <= 1'b0;
      rvalid <= 1'b0;
      rresp <= 2'h0;
      rdata <= `HSZ_RST32;
    end
    else if (aclken)
    begin
      rd_rdy_r <= !rd_rdy_r && !rvalid && arvalid;
      if (rd_hs)
      begin
        rvalid <= 1'b1;
        rresp <= rd_ok ? 2'h0 : 2'h2;
        rdata <= {16'h0000, rd_val};
      end
      else if (rready)
        rvalid <= 1'b0;
    end
  end

  // data words and the limit configuration
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lo_r <= `HSZ_RST16;
      hi_r <= `HSZ_RST16;
      limcfg_r <= `HSZ_RST16;
    end
    else if (aclken && wr_hs)
    begin
      if (awaddr == `HSZ_A_LOW)
        lo_r <= merge16(lo_r, wdata[15:0], wstrb[1:0]);
      if (awaddr == `HSZ_A_HIGH)
        hi_r <= merge16(hi_r, wdata[15:0], wstrb[1:0]);
      if (awaddr == `HSZ_A_LIMCFG)
        limcfg_r <= merge16(limcfg_r, wdata[15:0], wstrb[1:0]);
    end
  end

  // parameters loaded by command from the data words
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      accel_r <= `HSZ_RST32;
      init_speed_r <= `HSZ_RST32;
      spd_hi_r <= `HSZ_RST32;
      spd_lo_r <= `HSZ_RST32;
      ofs_r <= `HSZ_RST32;
      mode1_r <= `HSZ_RST16;
      mode2_r <= `HSZ_RST16;
    end
    else if (aclken && cmd_go)
    begin
      case (wdata[15:0])
        `HSZ_C_ACCEL: accel_r <= par;
        `HSZ_C_INIT_SPD: init_speed_r <= par;
        `HSZ_C_HI_SPD: spd_hi_r <= par;
        `HSZ_C_LO_SPD: spd_lo_r <= par;
        `HSZ_C_OFFSET: ofs_r <= par;
        `HSZ_C_MODE1: mode1_r <= lo_r;
        `HSZ_C_MODE2: mode2_r <= lo_r;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  hsz_pkg::hsz_state_e st_r;
  logic ent_r;
  logic esc_r;
  logic lim_err_r;
  logic [31:0] ofs_cnt_r;
  logic home_a;
  logic idx_a;
  logic idx_fall;
  logic lim_p_a;
  logic lim_m_a;
  logic s_dir;
  logic s_det;
  logic s_lim;
  logic lim_hit;
  logic start;

  assign home_a = !sync2_r[0];
  assign idx_a = !sync2_r[1];
  assign idx_fall = idx_d_r && !sync2_r[1];
  assign lim_p_a = sync2_r[2] == limcfg_r[`HSZ_LIM_POL];
  assign lim_m_a = sync2_r[3] == limcfg_r[`HSZ_LIM_POL];
  assign start = cmd_go && wdata[15:0] == `HSZ_C_START;

  always_comb
  begin
    s_dir = 1'b0;
    s_det = 1'b0;
    s_lim = 1'b0;
    case (st_r)
      hsz_pkg::HSZ_S1:
      begin
        s_dir = mode1_r[`HSZ_M1_S1_DIR];
        s_lim = mode1_r[`HSZ_M1_S1_DET +: 2] == 2'h2;
        case (mode1_r[`HSZ_M1_S1_DET +: 2])
          2'h1: s_det = home_a;
          2'h2: s_det = s_dir ? lim_m_a : lim_p_a;
          default: s_det = idx_a;
        endcase
      end
      hsz_pkg::HSZ_S2:
      begin
        s_dir = mode1_r[`HSZ_M1_S2_DIR] ^ esc_r;
        s_lim = mode1_r[`HSZ_M1_S2_DET];
        if (s_lim)
          s_det = mode1_r[`HSZ_M1_S2_DIR] ? lim_m_a : lim_p_a;
        else
          s_det = home_a;
      end
      hsz_pkg::HSZ_S3:
      begin
        s_dir = mode1_r[`HSZ_M1_S3_DIR];
        s_det = idx_a;
      end
      hsz_pkg::HSZ_S4: s_dir = !mode1_r[`HSZ_M1_S1_DIR];
      default: ;
    endcase
    // the detection limit never aborts its own step
    lim_hit = (s_dir ? lim_m_a : lim_p_a) && limcfg_r[`HSZ_LIM_EN] &&
              !(s_lim && !esc_r);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= hsz_pkg::HSZ_IDLE;
      ent_r <= 1'b0;
      esc_r <= 1'b0;
      lim_err_r <= 1'b0;
      ofs_cnt_r <= `HSZ_RST32;
      drive_r <= '0;
      pos_clr_r <= '0;
    end
    else if (aclken)
    begin
      ent_r <= 1'b0;
      pos_clr_r <= '0;
      drive_r.stop_now <= 1'b0;
      drive_r.dir <= s_dir;
      drive_r.offset <= 1'b0;
      if (st_r != hsz_pkg::HSZ_IDLE && st_r != hsz_pkg::HSZ_DONE &&
          lim_hit)
      begin
        drive_r.run <= 1'b0;
        drive_r.stop_now <= !limcfg_r[`HSZ_LIM_DEC];
        lim_err_r <= 1'b1;
        esc_r <= 1'b0;
        st_r <= hsz_pkg::HSZ_IDLE;
      end
      else
        case (st_r)
          hsz_pkg::HSZ_IDLE:
          begin
            drive_r.run <= 1'b0;
            if (start)
            begin
              st_r <= from_step(3'h1, mode1_r);
              ent_r <= 1'b1;
              lim_err_r <= 1'b0;
            end
          end
          // already on the signal at entry: step 1 ends at once
          hsz_pkg::HSZ_S1:
          begin
            drive_r.fast <= 1'b1;
            drive_r.run <= !s_det;
            if (s_det)
            begin
              st_r <= from_step(3'h2, mode1_r);
              ent_r <= 1'b1;
            end
          end
          // on the signal at entry: escape backwards, then search
          hsz_pkg::HSZ_S2:
          begin
            drive_r.fast <= 1'b0;
            drive_r.run <= 1'b1;
            if (s_det && ent_r)
              esc_r <= 1'b1;
            else if (s_det && !esc_r)
            begin
              drive_r.run <= 1'b0;
              pos_clr_r.lp <= mode1_r[`HSZ_M1_S2_LP];
              pos_clr_r.rp <= mode1_r[`HSZ_M1_S2_RP];
              st_r <= from_step(3'h3, mode1_r);
              ent_r <= 1'b1;
            end
            else if (!s_det)
              esc_r <= 1'b0;
          end
          hsz_pkg::HSZ_S3:
          begin
            drive_r.fast <= 1'b0;
            drive_r.run <= !s_det;
            if (s_det)
            begin
              drive_r.stop_now <= 1'b1;
              pos_clr_r.lp <= mode1_r[`HSZ_M1_S3_LP];
              pos_clr_r.rp <= mode1_r[`HSZ_M1_S3_RP];
              st_r <= from_step(3'h4, mode1_r);
              ent_r <= 1'b1;
            end
          end
          hsz_pkg::HSZ_S4:
          begin
            drive_r.fast <= 1'b1;
            if (ent_r)
            begin
              drive_r.run <= 1'b0;
              ofs_cnt_r <= ofs_r;
            end
            else if (ofs_cnt_r == `HSZ_RST32)
            begin
              drive_r.run <= 1'b0;
              st_r <= hsz_pkg::HSZ_DONE;
            end
            else
            begin
              // drop the request with the last pulse, else one step too many
              drive_r.run <= !(drive_pulse && ofs_cnt_r == 32'h00000001);
              drive_r.offset <= 1'b1;
              if (drive_pulse)
                ofs_cnt_r <= ofs_cnt_r - 32'h00000001;
            end
          end
          hsz_pkg::HSZ_DONE:
          begin
            drive_r.run <= 1'b0;
            pos_clr_r.lp <= mode2_r[`HSZ_M2_END_LP];
            pos_clr_r.rp <= mode2_r[`HSZ_M2_END_RP];
            st_r <= hsz_pkg::HSZ_IDLE;
          end
          default: st_r <= hsz_pkg::HSZ_IDLE;
        endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      speed_r <= `HSZ_RST32;
    else if (aclken)
      speed_r <= (st_r == hsz_pkg::HSZ_S2 || st_r == hsz_pkg::HSZ_S3) ?
                 spd_lo_r : spd_hi_r;
  end

  // ----------------------------------------------------------------
  // servo error clear pulse
  // ----------------------------------------------------------------
  logic [31:0] clr_cnt_r;
  logic [31:0] clr_cnt_nxt;
  logic [31:0] clr_len;
  logic clr_go;

  assign clr_len = 32'(clr_factor(mode2_r[`HSZ_M2_CLRW +: 3]) *
                       CLR_UNIT_CYC);
  assign clr_go = (st_r == hsz_pkg::HSZ_S3 && idx_fall &&
                   mode1_r[`HSZ_M1_S3_CLR]) ||
                  (st_r == hsz_pkg::HSZ_S2 && s_det && !esc_r &&
                   !ent_r && !lim_hit && mode1_r[`HSZ_M1_S2_CLR]);

  always_comb
  begin
    if (clr_go)
      clr_cnt_nxt = clr_len;
    else if (clr_cnt_r != `HSZ_RST32)
      clr_cnt_nxt = clr_cnt_r - 32'h00000001;
    else
      clr_cnt_nxt = clr_cnt_r;
  end

  // the idle level follows the polarity bit at once
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clr_cnt_r <= `HSZ_RST32;
      servo_error_clear_output <= 1'b0;
    end
    else if (aclken)
    begin
      clr_cnt_r <= clr_cnt_nxt;
      servo_error_clear_output <= mode2_r[`HSZ_M2_CLR_POL] ^
                                  (clr_cnt_nxt != `HSZ_RST32);
    end
  end

  assign status = {6'h00, sync2_r[3:2], !idx_a, !home_a,
                   clr_cnt_r != `HSZ_RST32, lim_err_r,
                   st_r != hsz_pkg::HSZ_IDLE, st_r};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk iff aclken);
  endclocking
  default disable iff (!aresetn);

  AST_START: assert property (start && st_r == hsz_pkg::HSZ_IDLE
    |=> st_r != hsz_pkg::HSZ_IDLE)
    else $error("start command did not leave idle");
  AST_ACCEL: assert property (cmd_go && wdata[15:0] == `HSZ_C_ACCEL
    |=> accel_r == $past(par))
    else $error("acceleration not loaded");
  AST_OFFSET: assert property (cmd_go && wdata[15:0] == `HSZ_C_OFFSET
    |=> ofs_r == $past(par))
    else $error("offset count not loaded");
  AST_LIMCFG: assert property (wr_hs && awaddr == `HSZ_A_LIMCFG &&
    wstrb[1:0] == 2'h3 |=> limcfg_r[12:10] == $past(wdata[12:10]))
    else $error("limit configuration bits not stored");
  AST_DETLIM: assert property (st_r == hsz_pkg::HSZ_S1 && s_lim &&
    s_det |=> !lim_err_r && st_r != hsz_pkg::HSZ_S1)
    else $error("detection limit treated as abort");
  AST_HOME: assert property (st_r == hsz_pkg::HSZ_S2 && !esc_r &&
    !ent_r && home_a && !s_lim && !lim_hit
    |=> st_r != hsz_pkg::HSZ_S2 && !drive_r.run)
    else $error("low speed step did not end on home");
  AST_ZSTOP: assert property (st_r == hsz_pkg::HSZ_S3 && idx_a
    && !lim_hit |=> drive_r.stop_now && !drive_r.run ##1 !drive_r.stop_now)
    else $error("index did not stop instantly");
  AST_CLRGO: assert property (st_r == hsz_pkg::HSZ_S3 && $fell(sync2_r[1])
    && mode1_r[`HSZ_M1_S3_CLR] |=> clr_cnt_r == $past(clr_len))
    else $error("clear pulse not started on index edge");
  AST_CLRPOL: assert property (clr_cnt_r != `HSZ_RST32
    |-> servo_error_clear_output == !mode2_r[`HSZ_M2_CLR_POL])
    else $error("clear pulse level wrong");
  AST_MODE2: assert property (cmd_go && wdata[15:0] == `HSZ_C_MODE2
    |=> mode2_r == $past(lo_r))
    else $error("mode word 2 not loaded");
  AST_S1DIR: assert property (st_r == hsz_pkg::HSZ_S1 && drive_r.run
    |-> drive_r.dir == mode1_r[`HSZ_M1_S1_DIR])
    else $error("step 1 direction wrong");

endmodule
`default_nettype wire

// *** design/hsz_consts.svh ***
/*
  Constants of the home search sequencer: register byte addresses,
  command codes, field positions, reset values and timing counts.
  Assumes a 200 MHz system clock.
*/
`ifndef HSZ_CONSTS_SVH
`define HSZ_CONSTS_SVH
`define HSZ_A_CMD 8'h00
`define HSZ_A_LOW 8'h04
`define HSZ_A_HIGH 8'h08
`define HSZ_A_LIMCFG 8'h0C
`define HSZ_A_MODE1 8'h10
`define HSZ_A_MODE2 8'h14
`define HSZ_A_STATUS 8'h18
`define HSZ_C_ACCEL 16'h0102
`define HSZ_C_INIT_SPD 16'h0104
`define HSZ_C_HI_SPD 16'h0105
`define HSZ_C_OFFSET 16'h0106
`define HSZ_C_LO_SPD 16'h0114
`define HSZ_C_MODE1 16'h0123
`define HSZ_C_MODE2 16'h0124
`define HSZ_C_START 16'h015A
`define HSZ_LIM_POL 10
`define HSZ_LIM_EN 11
`define HSZ_LIM_DEC 12
`define HSZ_M1_S1_EX 0
`define HSZ_M1_S1_DIR 1
`define HSZ_M1_S1_DET 2
`define HSZ_M1_S2_EX 4
`define HSZ_M1_S2_DIR 5
`define HSZ_M1_S2_DET 6
`define HSZ_M1_S2_CLR 7
`define HSZ_M1_S2_RP 8
`define HSZ_M1_S2_LP 9
`define HSZ_M1_S3_EX 10
`define HSZ_M1_S3_DIR 11
`define HSZ_M1_S3_CLR 12
`define HSZ_M1_S3_RP 13
`define HSZ_M1_S3_LP 14
`define HSZ_M1_S4_EX 15
`define HSZ_M2_GAP_EN 7
`define HSZ_M2_CLRW 4
`define HSZ_M2_CLR_POL 3
`define HSZ_M2_END_LP 2
`define HSZ_M2_END_RP 1
`define HSZ_M2_S23 0
`define HSZ_RST16 16'h0000
`define HSZ_RST32 32'h00000000
`define HSZ_CLK_NS 5
`define HSZ_CLR_UNIT_NS 10000
`define HSZ_CLR_UNIT_CYC (`HSZ_CLR_UNIT_NS / `HSZ_CLK_NS)
`endif

// *** design/hsz_pkg.sv ***
/*
  Types of the home search sequencer: sequencer states and the
  carriers for the drive request and the position clear strobes.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package hsz_pkg;
  // gray codes along the usual step order
  typedef enum logic [2:0] {
    HSZ_IDLE = 3'h0,
    HSZ_S1 = 3'h1,
    HSZ_S2 = 3'h3,
    HSZ_S3 = 3'h2,
    HSZ_S4 = 3'h6,
    HSZ_DONE = 3'h7
  } hsz_state_e;
  typedef struct packed {
    logic run;
    logic dir;
    logic fast;
    logic offset;
    logic stop_now;
  } hsz_drive_s;
  typedef struct packed {
    logic lp;
    logic rp;
  } hsz_pos_clr_s;
endpackage
`default_nettype wire

// *** dv/hsz_servo_model.sv ***
/*
  Servo driver and home sensor model for the home search bench.
  Assumes drive_r comes from the sequencer on the same clock.
*/
`default_nettype none
module hsz_servo_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire hsz_pkg::hsz_drive_s drive_r,
  output logic drive_pulse,
  output logic home_sensor_input_n,
  output logic encoder_index_input_n,
  output logic limit_plus_in,
  output logic limit_minus_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int pos;
  int div;
  // slow steps pulse every 6 cycles so the index stays low long enough
  always_ff @(posedge aclk)
  begin
    drive_pulse <= 1'b0;
    if (!aresetn)
    begin
      pos <= 0;
      div <= 0;
    end
    else if (drive_r.run)
    begin
      div <= div + 1;
      if (div >= (drive_r.fast ? 1 : 5))
      begin
        div <= 0;
        drive_pulse <= 1'b1;
        pos <= drive_r.dir ? pos - 1 : pos + 1;
      end
    end
  end
  assign home_sensor_input_n = !(pos <= -10);
  assign encoder_index_input_n = (pos & 7) != 0;
  // limits wired low active to match polarity bit 0
  assign limit_minus_in = !(pos <= -30);
  assign limit_plus_in = !(pos >= 20);
endmodule
`default_nettype wire

// *** dv/tb_home_search_zphase_sequencer.sv ***
/*
  Self-checking bench of the home search sequencer.
  Assumes the servo model in hsz_servo_model.sv and the design files.
*/
`include "hsz_consts.svh"
`default_nettype none
module tb_home_search_zphase_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CU = 4;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, drive_pulse, clr_out, pol;
  logic home_n, idx_n, lim_p, lim_m;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, speed, accel, init_spd, lo_spd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  hsz_pkg::hsz_drive_s drv;
  hsz_pkg::hsz_pos_clr_s pclr;
  int fail_count, tests_run, clr_len, last_len, clr_n, idx_bad;
  int stop_n, spd_bad, off_cnt, lp_n, rp_n;

  hsz_home_search #(.CLR_UNIT_CYC(CU)) dut_u (.aclk(aclk), .aclken(1'b1),
    .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .home_sensor_input_n(home_n), .encoder_index_input_n(idx_n),
    .limit_plus_in(lim_p), .limit_minus_in(lim_m),
    .drive_pulse(drive_pulse), .servo_error_clear_output(clr_out),
    .drive_r(drv), .pos_clr_r(pclr), .speed_r(speed), .accel_r(accel),
    .init_speed_r(init_spd));

  hsz_servo_model u_model (.aclk(aclk), .aresetn(aresetn), .drive_r(drv),
    .drive_pulse(drive_pulse), .home_sensor_input_n(home_n),
    .encoder_index_input_n(idx_n), .limit_plus_in(lim_p),
    .limit_minus_in(lim_m));

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // ----------------------------------------
  // output monitor
  // ----------------------------------------
  always @(posedge aclk)
  begin
    if (clr_out !== pol)
    begin
      if (clr_len == 0 && idx_n !== 1'b0)
        idx_bad++;
      clr_len++;
    end
    else if (clr_len > 0)
    begin
      last_len = clr_len;
      clr_n++;
      clr_len = 0;
    end
    if (drv.stop_now === 1'b1)
      stop_n++;
    if (drv.run === 1'b1 && drv.fast === 1'b0 && speed !== lo_spd)
      spd_bad++;
    if (drv.offset === 1'b1 && drive_pulse === 1'b1)
      off_cnt++;
    if (pclr.lp === 1'b1)
      lp_n++;
    if (pclr.rp === 1'b1)
      rp_n++;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic timeout(input string nm);
    fail_count++;
    $display("BAD %s expected=answer seen=timeout", nm);
    give_verdict();
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %s expected=%h seen=%h", nm, e, g);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      n++;
    end
    while (bvalid !== 1'b1 && n < 100);
    r = bresp;
    bready <= 1'b0;
    // let an edge pass so the next transfer never reassigns in this step
    @(posedge aclk);
    if (n >= 100)
      timeout("write");
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      n++;
    end
    while (rvalid !== 1'b1 && n < 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
    if (n >= 100)
      timeout("read");
  endtask

  // parameter goes low word, high word, then the command
  task automatic ld(input logic [15:0] c, input logic [31:0] v);
    logic [1:0] r;
    axw(`HSZ_A_LOW, {16'h0000, v[15:0]}, r);
    axw(`HSZ_A_HIGH, {16'h0000, v[31:16]}, r);
    axw(`HSZ_A_CMD, {16'h0000, c}, r);
  endtask

  task automatic run_search(output logic [31:0] d);
    int n;
    logic [1:0] r;
    @(negedge aclk);
    {clr_n, idx_bad, stop_n, spd_bad, off_cnt, lp_n, rp_n} = '0;
    // counters clear off the monitor edge; the bus moves after a rising one
    @(posedge aclk);
    ld(`HSZ_C_START, 32'h00000000);
    n = 0;
    do
    begin
      axr(`HSZ_A_STATUS, d, r);
      n++;
    end
    // the clear pulse outlasts the offset step, so wait it out too
    while ((d[3] !== 1'b0 || d[5] !== 1'b0) && n < 500);
    if (n >= 500)
      timeout("search");
  endtask

  initial
  begin
    logic [31:0] d, v;
    logic [1:0] r;
    logic [15:0] cd [3];
    int n_off;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, pol} = '0;
    {awaddr, araddr, wdata, lo_spd} = '0;
    wstrb = 4'hF;
    {fail_count, tests_run, clr_len, last_len} = '0;
    cd = '{`HSZ_C_ACCEL, `HSZ_C_INIT_SPD, `HSZ_C_HI_SPD};
    void'($urandom(17));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(`HSZ_A_LIMCFG, d, r);
    chk("limcfg_reset", 32'h00000000, d);
    v = {16'h0000, 16'($urandom)};
    axw(`HSZ_A_LIMCFG, v, r);
    axr(`HSZ_A_LIMCFG, d, r);
    chk("limcfg_rw", v, d);
    axr(8'h1C, d, r);
    chk("unmapped_resp", 32'h00000002, {30'h0, r});
    axw(`HSZ_A_MODE1, 32'h0000FFFF, r);
    chk("ro_write_resp", 32'h00000002, {30'h0, r});
    for (int i = 0; i < 3; i++)
    begin
      v = $urandom;
      ld(cd[i], v);
      chk("param_load", v, i == 0 ? accel : i == 1 ? init_spd : speed);
    end
    lo_spd = $urandom;
    ld(`HSZ_C_LO_SPD, lo_spd);
    $display("test registers done");
    // plus direction never meets home, so the enabled limit must abort
    // enabled limit with instant stop
    axw(`HSZ_A_LIMCFG, 32'h00000800, r);
    ld(`HSZ_C_MODE1, 32'h00000005);
    run_search(d);
    chk("limit_abort", 32'h00000001, {31'h0, d[4]});
    chk("abort_stop", 32'h00000001, 32'(stop_n));
    $display("test limit_abort done");
    axw(`HSZ_A_LIMCFG, 32'h00000000, r);
    n_off = 3 + $urandom % 6;
    ld(`HSZ_C_OFFSET, 32'(n_off));
    pol = 1'($urandom);
    ld(`HSZ_C_MODE2, 32'h00000026 | {28'h0, pol, 3'h0});
    ld(`HSZ_C_MODE1, 32'h0000FC37);
    run_search(d);
    chk("state_idle", 32'h00000000, {29'h0, d[2:0]});
    chk("clr_pulses", 32'h00000001, 32'(clr_n));
    chk("clr_width", 32'(10 * CU), 32'(last_len));
    chk("clr_on_index", 32'h00000000, 32'(idx_bad));
    chk("index_stop", 32'h00000001, 32'(stop_n));
    chk("slow_speed", 32'h00000000, 32'(spd_bad));
    chk("offset_pulses", 32'(n_off), 32'(off_cnt));
    // the index stops the model axis at -16
    chk("offset_end", 32'(n_off - 16), 32'(u_model.pos));
    chk("lp_clears", 32'h00000002, 32'(lp_n));
    chk("rp_clears", 32'h00000002, 32'(rp_n));
    $display("test index_search done");
    axw(`HSZ_A_LIMCFG, 32'h00001000, r);
    ld(`HSZ_C_MODE1, 32'h0000000B);
    run_search(d);
    chk("limit_detect", 32'h00000000, {31'h0, d[4]});
    chk("limit_reached", 32'h00000001, 32'(u_model.pos <= -30));
    $display("test limit_detect done");
    give_verdict();
  end
endmodule
`default_nettype wire
